//--- core/ebt_timer.sv
// Purpose: eight-bit up counter with two compare units and three flags
// Assumes: avalon-mm master on clk_in; acks come from the core's vectoring
// Notes:   every access takes two cycles; waitrequest drops on the second
//
// Contract
// RQ1: count and both compares are rw 8-bit
// RQ2: counter maximum is 0xFF
// RQ3: top is 0xFF or compare a by mode
// RQ4: prescaler or count pin, selected source and edge
// RQ5: select zero stops ticks, count holds
// RQ6: count readable and writable at any time
// RQ7: software count write beats clear or increment
// RQ8: equality sets compare flag on next tick
// RQ9: enabled flag requests; interrupt execution clears it
// RQ10: writing one clears a compare flag
// RQ11: count write blocks next tick's compare matches
// RQ12: normal mode counts up, wraps 0xFF to 0x00
// RQ13: overflow flag set when wrapping to zero
// RQ14: overflow flag cleared by interrupt execution
// RQ15: clear-on-match mode clears count at compare a
// RQ16: clear-on-match sets compare a flag at top
// RQ17: compare a unbuffered; missed top wraps first
// RQ18: clear-on-match sets overflow at max to zero
// RQ19: flags readable, each masked individually
// RQ20: power-off bit set keeps timer disabled
// RQ21: clock select decode table of eight codes
// RQ22: mode bit 3, select 2:0, rest zero
// RQ23: mask bits 2,1,0; request needs global enable
// RQ24: count pin synchronised and edge detected
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
module ebt_timer
  import ebt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // avalon-mm slave
  input  wire logic [4:0]  address_in,
  input  wire logic [3:0]  byteenable_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  // count pin
  input  wire logic        external_count_pin_in,
  // interrupt handshake with the core
  input  wire logic [2:0]  irq_ack_in,
  output logic      [2:0]  irq_out
);
  import ebt_pkg::*;

  typedef enum logic {bus_idle, bus_answer} ebt_bus_e;

  ebt_tick_if tick_if ();

  logic [7:0]  count_value;
  logic [7:0]  compare_a_value;
  logic [7:0]  compare_b_value;
  logic        clear_on_match_select;
  logic [2:0]  clock_source_select;
  logic        timer_power_off;
  logic        global_irq_enable;
  logic        compare_b_irq_enable;
  logic        compare_a_irq_enable;
  logic        overflow_irq_enable;
  logic        compare_b_flag;
  logic        compare_a_flag;
  logic        overflow_flag;
  logic        match_block;
  ebt_bus_e    bus_state;
  ebt_bus_e    next_bus_state;
  logic        stall;
  logic [7:0]  count_top;
  logic        top_reached;
  logic [31:0] read_word;
  logic        req_take;
  logic        wr_lane0;
  logic [7:0]  wr_byte;
  logic        wr_control;
  logic        wr_count;
  logic        wr_cmp_a;
  logic        wr_cmp_b;
  logic        wr_mask;
  logic        wr_flags;
  logic        wr_sysctl;
  logic        tick;
  logic        match_a;
  logic        match_b;
  logic        at_max;
  logic [7:0]  next_count;
  logic        next_ovf_flag;
  logic        next_cmp_a_flag;
  logic        next_cmp_b_flag;
  logic [2:0]  next_irq;

  assign tick_if.clock_source_select = clock_source_select;
  assign tick_if.timer_power_off     = timer_power_off;
  assign tick                        = tick_if.timer_tick;

  ebt_tick_gen u_tick_gen (
    .clk_in                (clk_in),
    .rst_b_in              (rst_b_in),
    .external_count_pin_in (external_count_pin_in),
    .tick_if               (tick_if)
  );

  // bus handshake: first cycle stalls, second cycle completes
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      bus_idle: begin
        if (read_in || write_in) begin
          next_bus_state = bus_answer;
        end
      end
      bus_answer: begin
        next_bus_state = bus_idle;
      end
      default: begin
        next_bus_state = bus_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_state <= bus_idle;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // own flop so waitrequest never passes through a decode
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stall <= 1'b1;
    end else begin
      stall <= (next_bus_state != bus_answer);
    end
  end

  assign waitrequest_out = stall;
  assign req_take        = (bus_state == bus_answer) && (read_in || write_in);
  assign wr_lane0        = req_take && write_in && byteenable_in[0];
  assign wr_byte         = writedata_in[7:0];

  // write decode, unmapped addresses are ignored
  assign wr_control = wr_lane0 && (address_in == EBT_ADDR_CONTROL);
  assign wr_count   = wr_lane0 && (address_in == EBT_ADDR_COUNT);
  assign wr_cmp_a   = wr_lane0 && (address_in == EBT_ADDR_CMP_A);
  assign wr_cmp_b   = wr_lane0 && (address_in == EBT_ADDR_CMP_B);
  assign wr_mask    = wr_lane0 && (address_in == EBT_ADDR_MASK);
  assign wr_flags   = wr_lane0 && (address_in == EBT_ADDR_FLAGS);
  assign wr_sysctl  = wr_lane0 && (address_in == EBT_ADDR_SYSCTL);

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (address_in)
      EBT_ADDR_CONTROL: begin
        read_word[EBT_CTL_MODE_BIT] = clear_on_match_select; // RQ22
        read_word[EBT_CTL_CS_MSB:EBT_CTL_CS_LSB] = clock_source_select;
      end
      EBT_ADDR_COUNT:   read_word[7:0] = count_value; // RQ1 RQ6
      EBT_ADDR_CMP_A:   read_word[7:0] = compare_a_value; // RQ1
      EBT_ADDR_CMP_B:   read_word[7:0] = compare_b_value; // RQ1
      EBT_ADDR_MASK: begin
        read_word[EBT_BIT_CMP_B] = compare_b_irq_enable; // RQ23
        read_word[EBT_BIT_CMP_A] = compare_a_irq_enable;
        read_word[EBT_BIT_OVF]   = overflow_irq_enable;
      end
      EBT_ADDR_FLAGS: begin
        read_word[EBT_BIT_CMP_B] = compare_b_flag; // RQ19
        read_word[EBT_BIT_CMP_A] = compare_a_flag;
        read_word[EBT_BIT_OVF]   = overflow_flag;
      end
      EBT_ADDR_SYSCTL: begin
        read_word[EBT_SYS_PWR_BIT] = timer_power_off;
        read_word[EBT_SYS_GIE_BIT] = global_irq_enable;
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  // read data captured in the stall cycle so it stands at the taking edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      readdata_out <= 32'h0000_0000;
    end else if (read_in && (bus_state == bus_idle)) begin
      readdata_out <= read_word;
    end
  end

  // control register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clear_on_match_select <= 1'b0;
      clock_source_select   <= EBT_CS_STOP;
    end else if (wr_control) begin
      clear_on_match_select <= wr_byte[EBT_CTL_MODE_BIT]; // RQ22
      clock_source_select   <= wr_byte[EBT_CTL_CS_MSB:EBT_CTL_CS_LSB]; // RQ22
    end
  end

  // compare registers take effect at once, no shadow copy
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      compare_a_value <= EBT_RST_REG8;
      compare_b_value <= EBT_RST_REG8;
    end else begin
      if (wr_cmp_a) begin
        compare_a_value <= wr_byte; // RQ1 RQ17
      end
      if (wr_cmp_b) begin
        compare_b_value <= wr_byte; // RQ1
      end
    end
  end

  // mask register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      compare_b_irq_enable <= 1'b0;
      compare_a_irq_enable <= 1'b0;
      overflow_irq_enable  <= 1'b0;
    end else if (wr_mask) begin
      compare_b_irq_enable <= wr_byte[EBT_BIT_CMP_B]; // RQ23
      compare_a_irq_enable <= wr_byte[EBT_BIT_CMP_A]; // RQ23
      overflow_irq_enable  <= wr_byte[EBT_BIT_OVF]; // RQ23
    end
  end

  // power-off and global interrupt enable
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_power_off   <= EBT_RST_PWROFF;
      global_irq_enable <= EBT_RST_GIE;
    end else if (wr_sysctl) begin
      timer_power_off   <= wr_byte[EBT_SYS_PWR_BIT]; // RQ20
      global_irq_enable <= wr_byte[EBT_SYS_GIE_BIT];
    end
  end

  // a count write blocks matches until the following tick has passed
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      match_block <= 1'b0;
    end else if (wr_count) begin
      match_block <= 1'b1; // RQ11
    end else if (tick) begin
      match_block <= 1'b0; // RQ11
    end
  end

  // comparators run every cycle; flag effect waits for a tick
  assign match_a = (count_value == compare_a_value) && !match_block; // RQ8 RQ11
  assign match_b = (count_value == compare_b_value) && !match_block; // RQ8 RQ11
  assign at_max  = (count_value == EBT_COUNT_MAX); // RQ2

  // top is 0xFF in normal mode, compare a in clear-on-match mode
  assign count_top   = clear_on_match_select ? compare_a_value : EBT_COUNT_MAX; // RQ3
  assign top_reached = (count_value == count_top); // RQ3

  // counter next value
  always_comb begin
    next_count = count_value;
    if (wr_count) begin
      next_count = wr_byte; // RQ6 RQ7
    end else if (tick) begin
      if (top_reached) begin
        next_count = EBT_COUNT_ZERO; // RQ3 RQ12 RQ15
      end else begin
        next_count = count_value + 8'h01; // RQ12 RQ17
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_value <= EBT_RST_REG8;
    end else begin
      count_value <= next_count;
    end
  end

  // flags: set beats software clear and interrupt acknowledge
  always_comb begin
    next_ovf_flag   = overflow_flag;
    next_cmp_a_flag = compare_a_flag;
    next_cmp_b_flag = compare_b_flag;
    if (irq_ack_in[EBT_BIT_OVF]) begin
      next_ovf_flag = 1'b0; // RQ14
    end
    if (irq_ack_in[EBT_BIT_CMP_A]) begin
      next_cmp_a_flag = 1'b0; // RQ9
    end
    if (irq_ack_in[EBT_BIT_CMP_B]) begin
      next_cmp_b_flag = 1'b0; // RQ9
    end
    if (wr_flags && wr_byte[EBT_BIT_OVF]) begin
      next_ovf_flag = 1'b0;
    end
    if (wr_flags && wr_byte[EBT_BIT_CMP_A]) begin
      next_cmp_a_flag = 1'b0; // RQ10
    end
    if (wr_flags && wr_byte[EBT_BIT_CMP_B]) begin
      next_cmp_b_flag = 1'b0; // RQ10
    end
    // a count write drops the increment, so no wrap happens then
    if (tick && !wr_count && at_max) begin
      next_ovf_flag = 1'b1; // RQ13 RQ18
    end
    if (tick && match_a) begin
      next_cmp_a_flag = 1'b1; // RQ8 RQ16
    end
    if (tick && match_b) begin
      next_cmp_b_flag = 1'b1; // RQ8
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overflow_flag  <= 1'b0;
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
    end else begin
      overflow_flag  <= next_ovf_flag;
      compare_a_flag <= next_cmp_a_flag;
      compare_b_flag <= next_cmp_b_flag;
    end
  end

  // request lines rise and fall together with the stored flags
  always_comb begin
    next_irq = 3'h0;
    next_irq[EBT_BIT_OVF]   = next_ovf_flag && overflow_irq_enable &&
                              global_irq_enable; // RQ19 RQ23
    next_irq[EBT_BIT_CMP_A] = next_cmp_a_flag && compare_a_irq_enable &&
                              global_irq_enable; // RQ9 RQ23
    next_irq[EBT_BIT_CMP_B] = next_cmp_b_flag && compare_b_irq_enable &&
                              global_irq_enable; // RQ9 RQ23
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 3'h0;
    end else begin
      irq_out <= next_irq;
    end
  end

endmodule : ebt_timer

//--- core/ebt_pkg.sv
// Purpose: shared constants for the eight-bit timer with two compare units
// Assumes: avalon-mm byte addresses, one aligned 32-bit word per register
// Notes:   registers are at most 8 bits wide in byte lane 0, upper bits read zero
package ebt_pkg;

  // register byte offsets
  localparam logic [4:0] EBT_ADDR_CONTROL = 5'h00;
  localparam logic [4:0] EBT_ADDR_COUNT   = 5'h04;
  localparam logic [4:0] EBT_ADDR_CMP_A   = 5'h08;
  localparam logic [4:0] EBT_ADDR_CMP_B   = 5'h0C;
  localparam logic [4:0] EBT_ADDR_MASK    = 5'h10;
  localparam logic [4:0] EBT_ADDR_FLAGS   = 5'h14;
  localparam logic [4:0] EBT_ADDR_SYSCTL  = 5'h18;

  // timer_control fields
  localparam int EBT_CTL_MODE_BIT  = 3;
  localparam int EBT_CTL_CS_MSB    = 2;
  localparam int EBT_CTL_CS_LSB    = 0;
  // mask and flag bit positions
  localparam int EBT_BIT_CMP_B     = 2;
  localparam int EBT_BIT_CMP_A     = 1;
  localparam int EBT_BIT_OVF       = 0;
  // system control fields
  localparam int EBT_SYS_PWR_BIT   = 0;
  localparam int EBT_SYS_GIE_BIT   = 1;

  // reset values
  localparam logic [7:0] EBT_RST_REG8   = 8'h00;
  localparam logic       EBT_RST_PWROFF = 1'b0;
  localparam logic       EBT_RST_GIE    = 1'b0;

  // counter limits
  localparam logic [7:0] EBT_COUNT_MAX  = 8'hFF;
  localparam logic [7:0] EBT_COUNT_ZERO = 8'h00;

  // clock source select codes
  localparam logic [2:0] EBT_CS_STOP    = 3'h0;
  localparam logic [2:0] EBT_CS_DIV1    = 3'h1;
  localparam logic [2:0] EBT_CS_DIV8    = 3'h2;
  localparam logic [2:0] EBT_CS_DIV64   = 3'h3;
  localparam logic [2:0] EBT_CS_DIV256  = 3'h4;
  localparam logic [2:0] EBT_CS_DIV1024 = 3'h5;
  localparam logic [2:0] EBT_CS_PIN_FALL = 3'h6;
  localparam logic [2:0] EBT_CS_PIN_RISE = 3'h7;

  // prescaler terminal masks: tick when masked bits are all ones
  localparam logic [9:0] EBT_PRE_M8    = 10'h007;
  localparam logic [9:0] EBT_PRE_M64   = 10'h03F;
  localparam logic [9:0] EBT_PRE_M256  = 10'h0FF;
  localparam logic [9:0] EBT_PRE_M1024 = 10'h3FF;

endpackage : ebt_pkg

//--- core/ebt_tick_if.sv
// Purpose: carries clock source choice and the timer tick between modules
// Assumes: single clock domain
// Notes:   tick is a one-cycle enable
interface ebt_tick_if;
  logic [2:0] clock_source_select;
  logic       timer_power_off;
  logic       timer_tick;

  modport ctrl (output clock_source_select, output timer_power_off, input timer_tick);
  modport gen  (input clock_source_select, input timer_power_off, output timer_tick);
endinterface : ebt_tick_if

//--- core/ebt_tick_gen.sv
// Purpose: prescaler and count pin edge detector producing the timer tick
// Assumes: pin is asynchronous to clk_in
// Notes:   prescaler is free running, so the first divided tick may come early
module ebt_tick_gen
  import ebt_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // pin
  input  wire logic external_count_pin_in,
  // link to core
  ebt_tick_if.gen   tick_if
);

  logic [9:0] prescale;
  logic       pin_meta;
  logic       pin_sync;
  logic       pin_prev;
  logic       next_tick;
  logic       tick;

  // prescaler held in reset while powered off
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescale <= 10'h000;
    end else if (tick_if.timer_power_off) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // two-stage synchroniser then edge history
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= external_count_pin_in; // RQ24
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  always_comb begin
    case (tick_if.clock_source_select) // RQ21
      EBT_CS_STOP:     next_tick = 1'b0; // RQ5
      EBT_CS_DIV1:     next_tick = 1'b1;
      EBT_CS_DIV8:     next_tick = &(prescale | ~EBT_PRE_M8);
      EBT_CS_DIV64:    next_tick = &(prescale | ~EBT_PRE_M64);
      EBT_CS_DIV256:   next_tick = &(prescale | ~EBT_PRE_M256);
      EBT_CS_DIV1024:  next_tick = &(prescale | ~EBT_PRE_M1024);
      EBT_CS_PIN_FALL: next_tick = pin_prev & ~pin_sync; // RQ4 RQ24
      EBT_CS_PIN_RISE: next_tick = ~pin_prev & pin_sync; // RQ4 RQ24
      default:         next_tick = 1'b0;
    endcase
    if (tick_if.timer_power_off) begin
      next_tick = 1'b0; // RQ20
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick <= 1'b0;
    end else begin
      tick <= next_tick;
    end
  end

  assign tick_if.timer_tick = tick;

endmodule : ebt_tick_gen

//--- test/ebt_timer_checker.sv
// Purpose: port checks for the timer
// Assumes: bound to ebt_timer
// Notes:   sees bus and request pins only
module ebt_timer_checker
  import ebt_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // bus
  input wire logic [4:0]  address_in,
  input wire logic [3:0]  byteenable_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  // requests
  input wire logic [2:0]  irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic rd_take;
  logic wr_take;
  assign rd_take = read_in & ~waitrequest_out;
  assign wr_take = write_in & ~waitrequest_out & byteenable_in[0];

  chk_wait_drop: assert property ((read_in | write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("access not answered");
  chk_wait_back: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("wait low too long");
  chk_wait_idle: assert property (!(read_in | write_in) |=> waitrequest_out)
    else $error("wait low when idle");
  chk_data_upper: assert property (readdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_ctrl_zero: assert property (rd_take && address_in == EBT_ADDR_CONTROL |-> readdata_out[7:4] == 4'h0)
    else $error("control upper bits set");
  chk_flag_zero: assert property (rd_take && (address_in == EBT_ADDR_MASK ||
      address_in == EBT_ADDR_FLAGS) |-> readdata_out[7:3] == 5'h00)
    else $error("mask or flag upper bits set");
  chk_hole_zero: assert property (rd_take && address_in == 5'h1C |-> readdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_gie_off: assert property (wr_take && address_in == EBT_ADDR_SYSCTL &&
      !writedata_in[EBT_SYS_GIE_BIT] |-> ##2 irq_out == 3'h0)
    else $error("request without global enable");
  chk_mask_off: assert property (wr_take && address_in == EBT_ADDR_MASK
      |-> ##2 (irq_out & ~$past(writedata_in[2:0], 2)) == 3'h0)
    else $error("masked request raised");
endmodule : ebt_timer_checker

//--- test/ebt_core_model.sv
// Purpose: core model that services timer requests
// Assumes: one ack pulse per request after a service delay
// Notes:   served keeps every request ever serviced
module ebt_core_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // requests and acks
  input  wire logic [2:0] irq_in,
  output logic      [2:0] irq_ack_out,
  output logic      [2:0] served_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;

  // restart after each ack so a request that is still falling is not acked twice
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_cnt    <= 2'h0;
      irq_ack_out <= 3'h0;
      served_out  <= 3'h0;
    end else if (irq_ack_out != 3'h0 || irq_in == 3'h0) begin
      wait_cnt    <= 2'h0;
      irq_ack_out <= 3'h0;
    end else if (wait_cnt == 2'h3) begin
      irq_ack_out <= irq_in;
      served_out  <= served_out | irq_in;
    end else begin
      wait_cnt    <= wait_cnt + 2'h1;
    end
  end
endmodule : ebt_core_model

//--- test/testbench.sv
// Purpose: self-checking bench for the timer
// Assumes: count pin held four cycles per level
// Notes:   prescaled rates judged in a small window
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ebt_pkg::*;
  logic        clk_in;
  logic        rst_b_in;
  logic [4:0]  address_in;
  logic [3:0]  byteenable_in;
  logic        read_in;
  logic        write_in;
  logic [31:0] writedata_in;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic        pin;
  logic [2:0]  irq_ack;
  logic [2:0]  irq_out;
  logic [2:0]  served;
  logic [31:0] q;
  int          n_mismatch;
  int          checked;

  ebt_timer u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .address_in(address_in),
    .byteenable_in(byteenable_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .external_count_pin_in(pin),
    .irq_ack_in(irq_ack), .irq_out(irq_out));
  ebt_core_model u_core (.clk_in(clk_in), .rst_b_in(rst_b_in), .irq_in(irq_out),
    .irq_ack_out(irq_ack), .served_out(served));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // idx: 0 control, 1 count, 2 cmp a, 3 cmp b, 4 mask, 5 flags, 6 sysctl, 7 hole
  task automatic bus(input logic wr, input int idx, input logic [7:0] d);
    write_in     <= wr;
    read_in      <= ~wr;
    address_in   <= 5'(idx * 4);
    writedata_in <= {24'h00_0000, d};
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in     <= 1'b0;
    read_in      <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic wr(input int idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rc(input int idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(q, {24'h00_0000, e});
  endtask : rc

  // slow edges so the synchroniser never misses one
  task automatic pulse(input int n);
    repeat (n) begin
      pin <= 1'b1;
      repeat (4) @(posedge clk_in);
      pin <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask : pulse

  task automatic t_regs();
    for (int i = 0; i < 8; i++) rc(i, 8'h00);
    for (int i = 1; i < 4; i++) begin
      wr(i, 8'hA5);
      rc(i, 8'hA5);
    end
    wr(0, 8'hF8);
    rc(0, 8'h08);
    wr(4, 8'hFF);
    rc(4, 8'h07);
    wr(7, 8'h5A);
    rc(7, 8'h00);
    byteenable_in <= 4'h0;
    wr(1, 8'h11);
    byteenable_in <= 4'hF;
    rc(1, 8'hA5);
    wr(0, 8'h00);
    wr(4, 8'h00);
  endtask : t_regs

  task automatic t_pin();
    wr(1, 8'h20);
    wr(0, 8'h07);
    pulse(3);
    rc(1, 8'h23);
    wr(0, 8'h06);
    pulse(2);
    rc(1, 8'h25);
    wr(6, 8'h01);
    pulse(2);
    rc(1, 8'h25);
    wr(6, 8'h00);
    wr(0, 8'h00);
    pulse(2);
    rc(1, 8'h25);
  endtask : t_pin

  task automatic t_ovf();
    wr(1, 8'hFE);
    wr(0, 8'h07);
    pulse(2);
    rc(1, 8'h00);
    rc(5, 8'h01);
    pulse(1);
    rc(5, 8'h01);
    wr(5, 8'h01);
    rc(5, 8'h00);
  endtask : t_ovf

  task automatic t_cmp();
    wr(0, 8'h00);
    wr(2, 8'h05);
    wr(3, 8'h05);
    wr(1, 8'h05);
    wr(0, 8'h07);
    pulse(1);
    rc(5, 8'h00);
    wr(1, 8'h04);
    pulse(2);
    rc(5, 8'h06);
    wr(5, 8'h02);
    rc(5, 8'h04);
    wr(5, 8'h00);
    rc(5, 8'h04);
    wr(5, 8'h04);
  endtask : t_cmp

  task automatic t_ctc();
    wr(0, 8'h00);
    wr(2, 8'h03);
    wr(1, 8'h00);
    wr(0, 8'h0F);
    pulse(4);
    rc(1, 8'h00);
    rc(5, 8'h02);
    wr(1, 8'hFE);
    pulse(2);
    rc(1, 8'h00);
    rc(5, 8'h03);
  endtask : t_ctc

  task automatic t_irq();
    wr(0, 8'h00);
    wr(4, 8'h07);
    repeat (4) @(posedge clk_in);
    check({29'h0, irq_out}, 32'h0000_0000);
    wr(4, 8'h02);
    wr(6, 8'h02);
    repeat (16) @(posedge clk_in);
    check({29'h0, served}, 32'h0000_0002);
    rc(5, 8'h01);
    wr(4, 8'h07);
    repeat (16) @(posedge clk_in);
    check({29'h0, served}, 32'h0000_0003);
    rc(5, 8'h00);
    wr(6, 8'h00);
    wr(4, 8'h00);
  endtask : t_irq

  // prescaler phase is free running and bus cycles add ticks, so allow one tick below and up to four above
  task automatic t_rates();
    int dv [5] = '{1, 8, 64, 256, 1024};
    for (int c = 1; c < 6; c++) begin
      wr(1, 8'h00);
      wr(0, 8'(c));
      repeat (16 * dv[c-1]) @(posedge clk_in);
      wr(0, 8'h00);
      bus(1'b0, 1, 8'h00);
      check({31'h0, q[7:0] inside {[15:20]}}, 32'h0000_0001);
    end
    wr(0, 8'h01);
    wr(1, 8'h80);
    wr(0, 8'h00);
    bus(1'b0, 1, 8'h00);
    check({31'h0, q[7:0] inside {[128:132]}}, 32'h0000_0001);
  endtask : t_rates

  initial begin
    rst_b_in      = 1'b0;
    address_in    = 5'h00;
    byteenable_in = 4'hF;
    read_in       = 1'b0;
    write_in      = 1'b0;
    writedata_in  = 32'h0000_0000;
    pin           = 1'b0;
    n_mismatch    = 0;
    checked       = 0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_pin();
    t_ovf();
    t_cmp();
    t_ctc();
    t_irq();
    t_rates();
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    stop_test();
  end
endmodule : testbench

bind ebt_timer ebt_timer_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .address_in(address_in), .byteenable_in(byteenable_in), .read_in(read_in),
  .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .irq_out(irq_out));
